// ---- dv/rtcs_calendar_checker.sv ----
// port-level assertions for the clock, calendar and interval block
`timescale 1ns/100ps
`default_nettype none

module rtcs_calendar_checker
#(
  parameter int unsigned TICKS_PER_SEC = rtcs_pkg::SEC_CYCLES
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  // mission and status
  input wire logic        missionActive,
  input wire logic        startCmd,
  input wire logic        oscillatorRun,
  input wire logic        sampleUnitSeconds,
  input wire logic        secondTick,
  input wire logic        logStrobe
);
  import rtcs_pkg::*;

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // control write that is not dropped by a mission
  wire logic wrCtrl;
  assign wrCtrl = regWrEn && !missionActive && regAddr == ADDR_RTC_CTRL;

  // control bits follow writes and start commands, frozen in mission
  osc_start_a: assert property (startCmd |=> oscillatorRun)
    else $error("start command left oscillator stopped");
  osc_stop_a: assert property (wrCtrl && !startCmd && !regWrData[0] |=> !oscillatorRun)
    else $error("oscillator still running after stop write");
  unit_set_a: assert property (wrCtrl && regWrData[1] |=> sampleUnitSeconds)
    else $error("unit bit not set by control write");
  mission_lock_a: assert property (missionActive && !startCmd |=> $stable(oscillatorRun) && $stable(sampleUnitSeconds))
    else $error("control changed during mission");

  // second ticks only while running, at least nine cycles apart
  tick_idle_a: assert property (!oscillatorRun |-> !secondTick)
    else $error("tick while oscillator stopped");
  tick_gap_a: assert property (secondTick |=> !secondTick [*8])
    else $error("second ticks too close");
  strobe_cause_a: assert property (logStrobe |-> $past(secondTick) && $past(missionActive))
    else $error("log strobe without tick in mission");

  // read data keeps constant-zero cells and bcd digits
  ctrl_zero_a: assert property (regRdEn && regAddr == ADDR_RTC_CTRL |=> regRdData[7:2] == 6'h00)
    else $error("control reads nonzero high bits");
  sec_bcd_a: assert property (regRdEn && regAddr == ADDR_SEC |=> !regRdData[7] && regRdData[3:0] <= 4'h9)
    else $error("seconds read not bcd");
endmodule : rtcs_calendar_checker

bind rtcs_calendar rtcs_calendar_checker #(.TICKS_PER_SEC(TICKS_PER_SEC)) chk_u
(
  .clk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .missionActive, .startCmd, .oscillatorRun, .sampleUnitSeconds, .secondTick, .logStrobe
);

`default_nettype wire

// ---- dv/rtcs_host_model.sv ----
// host model driving the register port and mission lines
`timescale 1ns/100ps
`default_nettype none

module rtcs_host_model
(
  // clock
  input  wire logic        clk,
  // register port
  output logic      [15:0] regAddr,
  output logic      [7:0]  regWrData,
  output logic             regWrEn,
  output logic             regRdEn,
  input  wire logic [7:0]  regRdData,
  // mission control
  output logic             missionActive,
  output logic             startCmd
);
  import rtcs_pkg::*;

  // idle lines at time zero
  initial
  begin
    regAddr = 16'h0000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    missionActive = 1'b0;
    startCmd = 1'b0;
  end

  // one write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr

  // one read; data is valid after the edge that took it
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd

  task automatic rdTime(output logic [7:0] t [6]);
    for (int i = 0; i < 6; i++)
      rd(ADDR_SEC + 16'(i), t[i]);
  endtask : rdTime

  task automatic setRate(input logic [13:0] r, input logic [7:0] c);
    wr(ADDR_RATE_LO, r[7:0]);
    wr(ADDR_RATE_HI, {2'b00, r[13:8]});
    wr(ADDR_RTC_CTRL, c);
  endtask : setRate

  // mission level and start strobe
  task automatic setMission(input logic m);
    @(negedge clk);
    missionActive = m;
  endtask : setMission

  task automatic start();
    @(negedge clk);
    startCmd = 1'b1;
    @(negedge clk);
    startCmd = 1'b0;
  endtask : start
endmodule : rtcs_host_model

`default_nettype wire

// ---- dv/tb.sv ----
// self-checking testbench for the clock, calendar and interval block
`timescale 1ns/100ps
`default_nettype none

module tb;
  import rtcs_pkg::*;

  // ----------
  // signals
  // ----------
  localparam int TPS = 10;
  localparam logic [15:0] MA [9] = '{ADDR_SEC, ADDR_HOUR, ADDR_DATE, ADDR_MONTH, ADDR_YEAR,
                                    ADDR_RATE_LO, ADDR_RATE_HI, ADDR_RTC_CTRL, 16'h0210};
  localparam logic [7:0]  MW [9] = '{8'hd9, 8'h92, 8'he9, 8'he9, 8'h99, 8'hff, 8'hff, 8'hfe, 8'h55};
  localparam logic [7:0]  ME [9] = '{8'h59, 8'h12, 8'h29, 8'h89, 8'h99, 8'hff, 8'h3f, 8'h02, 8'h00};
  logic        clk;
  logic        rst_b;
  logic [15:0] regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData;
  logic        missionActive;
  logic        startCmd;
  logic        oscillatorRun;
  logic        sampleUnitSeconds;
  logic        secondTick;
  logic        logStrobe;
  logic [7:0]  v;
  logic [7:0]  t [6];
  int          errCount;
  int          nChecks;

  // short divider keeps a simulated second at ten cycles
  rtcs_calendar #(.TICKS_PER_SEC(TPS)) dut_u
  (
    .clk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .missionActive,
    .startCmd, .oscillatorRun, .sampleUnitSeconds, .secondTick, .logStrobe
  );

  rtcs_host_model host_u
  (
    .clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .missionActive, .startCmd
  );

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------
  // helpers
  // ----------
  task automatic stopTest();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stopTest

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bounded wait for a tick or a log strobe, counting cycles
  task automatic waitEv(input logic strb, output int n);
    n = 0;
    while ((strb ? logStrobe : secondTick) !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 1000)
      begin
        errCount++;
        $display("Error event wait expected strobe seen none");
        stopTest();
      end
    end
  endtask : waitEv

  // set a time one second before a rollover, run one tick, read it back
  task automatic roll(input logic [7:0] y, m, d, h, ey, em, ed, eh);
    int n;
    host_u.wr(ADDR_RTC_CTRL, 8'h02);
    host_u.wr(ADDR_YEAR, y);
    host_u.wr(ADDR_MONTH, m);
    host_u.wr(ADDR_DATE, d);
    host_u.wr(ADDR_HOUR, h);
    host_u.wr(ADDR_MIN, 8'h59);
    host_u.wr(ADDR_SEC, 8'h59);
    host_u.wr(ADDR_RTC_CTRL, 8'h03);
    host_u.rd(ADDR_SEC, v);
    chk("snapshot seconds", 8'h59, v);
    waitEv(1'b0, n);
    host_u.rd(ADDR_MIN, v);
    chk("snapshot minutes", 8'h59, v);
    host_u.wr(ADDR_RTC_CTRL, 8'h02);
    host_u.rdTime(t);
    chk("seconds", 8'h00, t[0]);
    chk("minutes", 8'h00, t[1]);
    chk("hours", eh, t[2]);
    chk("date", ed, t[3]);
    chk("month", em, t[4]);
    chk("year", ey, t[5]);
    $display("test roll %h %h done", y, h);
  endtask : roll

  // program an interval, then time two log strobes in a mission
  task automatic rateRun(input logic [13:0] r, input logic [7:0] c, input int e);
    int n;
    host_u.setRate(r, c);
    chk("unit bit", {7'h00, c[1]}, {7'h00, sampleUnitSeconds});
    host_u.setMission(1'b1);
    waitEv(1'b1, n);
    @(negedge clk);
    waitEv(1'b1, n);
    host_u.setMission(1'b0);
    nChecks++;
    if (n != e - 1)
    begin
      errCount++;
      $display("Error strobe gap expected %0d seen %0d", e, n + 1);
    end
    $display("test rate %h done", r);
  endtask : rateRun

  // ----------
  // sequence
  // ----------
  initial
  begin
    errCount = 0;
    nChecks = 0;
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    // interval comes out of reset at its documented floor
    host_u.rd(ADDR_RATE_LO, v);
    chk("reset interval", RST_RATE[7:0], v);
    // constant-zero cells, interval width and an unmapped place
    for (int i = 0; i < 9; i++)
    begin
      host_u.wr(MA[i], MW[i]);
      host_u.rd(ADDR_SEC, v);
      host_u.rd(MA[i], v);
      chk("masked register", ME[i], v);
    end
    $display("test masks done");
    // writes dropped in mission, start command still runs the oscillator
    host_u.setMission(1'b1);
    host_u.wr(ADDR_SEC, 8'h12);
    host_u.wr(ADDR_RTC_CTRL, 8'h01);
    host_u.rd(ADDR_SEC, v);
    chk("locked seconds", 8'h59, v);
    host_u.rd(ADDR_RTC_CTRL, v);
    chk("locked control", 8'h02, v);
    host_u.start();
    host_u.setMission(1'b0);
    host_u.rd(ADDR_RTC_CTRL, v);
    chk("started control", 8'h03, v);
    $display("test mission done");
    // rollovers: century, leap years, both hour formats
    roll(8'h99, 8'h12, 8'h31, 8'h23, 8'h00, 8'h81, 8'h01, 8'h00);
    roll(8'h00, 8'h02, 8'h28, 8'h23, 8'h00, 8'h02, 8'h29, 8'h00);
    roll(8'h04, 8'h02, 8'h28, 8'h23, 8'h04, 8'h02, 8'h29, 8'h00);
    roll(8'h01, 8'h02, 8'h28, 8'h23, 8'h01, 8'h03, 8'h01, 8'h00);
    roll(8'h01, 8'h05, 8'h10, 8'h19, 8'h01, 8'h05, 8'h10, 8'h20);
    roll(8'h01, 8'h05, 8'h10, 8'h51, 8'h01, 8'h05, 8'h10, 8'h72);
    // interval zero, a plain interval, minute unit
    rateRun(14'h0000, 8'h03, TPS);
    rateRun(14'h0003, 8'h03, 3 * TPS);
    rateRun(14'h0001, 8'h01, 60 * TPS);
    stopTest();
  end
endmodule : tb

`default_nettype wire

// ---- logic/rtcs_bcd_step.sv ----
// one bcd counter step with programmable wrap limit
`timescale 1ns/100ps
`default_nettype none

module rtcs_bcd_step
(
  // current value and limits
  input  wire logic [7:0] cur,
  input  wire logic [7:0] maxVal,
  input  wire logic [7:0] minVal,
  // stepped value
  output logic      [7:0] nxt,
  output logic            wrap
);

  // ---------------------------------------------------------------
  // increment
  // ---------------------------------------------------------------

  // values at or past the limit wrap, so a bad host write recovers
  always_comb
  begin
    wrap = (cur >= maxVal);
    if (wrap)
    begin
      nxt = minVal;
    end
    else if (cur[3:0] >= 4'h9)
    begin
      nxt = {4'(cur[7:4] + 4'h1), 4'h0};
    end
    else
    begin
      nxt = {cur[7:4], 4'(cur[3:0] + 4'h1)};
    end
  end

endmodule : rtcs_bcd_step

`default_nettype wire

// ---- logic/rtcs_calendar.sv ----
// real-time clock, calendar and sample interval timer
`timescale 1ns/100ps
`default_nettype none

module rtcs_calendar
#(
  parameter int unsigned TICKS_PER_SEC = rtcs_pkg::SEC_CYCLES
)
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // register port
  input  wire logic [rtcs_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [rtcs_pkg::DATA_W-1:0] regWrData,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  output logic      [rtcs_pkg::DATA_W-1:0] regRdData,
  // mission control
  input  wire logic                        missionActive,
  input  wire logic                        startCmd,
  // status and logging
  output logic                             oscillatorRun,
  output logic                             sampleUnitSeconds,
  output logic                             secondTick,
  output logic                             logStrobe
);

  import rtcs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] secQ;
  logic [DATA_W-1:0] minQ;
  logic [DATA_W-1:0] hourQ;
  logic [DATA_W-1:0] dateQ;
  logic [DATA_W-1:0] monthQ;
  logic [DATA_W-1:0] yearQ;
  logic [DATA_W-1:0] snapMinQ;
  logic [DATA_W-1:0] snapHourQ;
  logic [DATA_W-1:0] snapDateQ;
  logic [DATA_W-1:0] snapMonthQ;
  logic [DATA_W-1:0] snapYearQ;
  logic [DATA_W-1:0] rdDataQ;
  logic [RATE_W-1:0] rateQ;
  logic [RATE_W-1:0] remainQ;
  logic [DIV_W-1:0]  divQ;
  logic              oscRunQ;
  logic              unitSecQ;
  logic              logStrobeQ;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic wrOpen;
  logic wrSec;
  logic wrMin;
  logic wrHour;
  logic wrDate;
  logic wrMonth;
  logic wrYear;
  logic wrRateLo;
  logic wrRateHi;
  logic wrCtrl;

  assign wrOpen   = regWrEn && !missionActive;
  assign wrSec    = wrOpen && (regAddr == ADDR_SEC);
  assign wrMin    = wrOpen && (regAddr == ADDR_MIN);
  assign wrHour   = wrOpen && (regAddr == ADDR_HOUR);
  assign wrDate   = wrOpen && (regAddr == ADDR_DATE);
  assign wrMonth  = wrOpen && (regAddr == ADDR_MONTH);
  assign wrYear   = wrOpen && (regAddr == ADDR_YEAR);
  assign wrRateLo = wrOpen && (regAddr == ADDR_RATE_LO);
  assign wrRateHi = wrOpen && (regAddr == ADDR_RATE_HI);
  assign wrCtrl   = wrOpen && (regAddr == ADDR_RTC_CTRL);

  // ---------------------------------------------------------------
  // oscillator and one-second divider
  // ---------------------------------------------------------------
  logic secTick;

  assign secTick = oscRunQ && (divQ == DIV_W'(TICKS_PER_SEC - 1));

  // start commands force oscillator
  // a start command wins over a host write that clears the bit
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oscRunQ <= 1'b0;
    end
    else if (startCmd)
    begin
      oscRunQ <= 1'b1;
    end
    else if (wrCtrl)
    begin
      oscRunQ <= regWrData[CTRL_OSC_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      unitSecQ <= 1'b0;
    end
    else if (wrCtrl)
    begin
      unitSecQ <= regWrData[CTRL_UNIT_BIT];
    end
  end

  // divider restarts at a seconds write so the new second is whole
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divQ <= '0;
    end
    else if (!oscRunQ || wrSec || secTick)
    begin
      divQ <= '0;
    end
    else
    begin
      divQ <= divQ + DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // bcd steppers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] secNext;
  logic [DATA_W-1:0] minNext;
  logic [DATA_W-1:0] hour24Next;
  logic [DATA_W-1:0] hour12Next;
  logic [DATA_W-1:0] dateNext;
  logic [DATA_W-1:0] monthNext;
  logic [DATA_W-1:0] yearNext;
  logic [DATA_W-1:0] daysInMonth;
  logic              secWrap;
  logic              minWrap;
  logic              hour24Wrap;
  logic              dateWrap;
  logic              monthWrap;
  logic              yearWrap;

  // seconds and minutes roll at 59
  rtcs_bcd_step uSec
  (
    .cur    (secQ),
    .maxVal (BCD_59),
    .minVal (BCD_ZERO),
    .nxt    (secNext),
    .wrap   (secWrap)
  );

  rtcs_bcd_step uMin
  (
    .cur    (minQ),
    .maxVal (BCD_59),
    .minVal (BCD_ZERO),
    .nxt    (minNext),
    .wrap   (minWrap)
  );

  // bit 5 counts as twenties digit
  rtcs_bcd_step uHour24
  (
    .cur    ({2'b00, hourQ[5:0]}),
    .maxVal (BCD_23),
    .minVal (BCD_ZERO),
    .nxt    (hour24Next),
    .wrap   (hour24Wrap)
  );

  // twelve-hour count runs 01..12 in the low five bits
  rtcs_bcd_step uHour12
  (
    .cur    ({3'b000, hourQ[4:0]}),
    .maxVal (BCD_12),
    .minVal (BCD_ONE),
    .nxt    (hour12Next),
    .wrap   ()
  );

  rtcs_bcd_step uDate
  (
    .cur    (dateQ),
    .maxVal (daysInMonth),
    .minVal (BCD_ONE),
    .nxt    (dateNext),
    .wrap   (dateWrap)
  );

  rtcs_bcd_step uMonth
  (
    .cur    (monthQ & MASK_MONNUM),
    .maxVal (BCD_12),
    .minVal (BCD_ONE),
    .nxt    (monthNext),
    .wrap   (monthWrap)
  );

  rtcs_bcd_step uYear
  (
    .cur    (yearQ),
    .maxVal (BCD_99),
    .minVal (BCD_ZERO),
    .nxt    (yearNext),
    .wrap   (yearWrap)
  );

  // ---------------------------------------------------------------
  // hour format and month length
  // ---------------------------------------------------------------
  logic              mode12;
  logic              isPm;
  logic              atEleven;
  logic              dayCarry;
  logic              leapYear;
  logic [DATA_W-1:0] hourNext;
  logic [DATA_W-1:0] monthNum;

  assign mode12   = hourQ[HOUR_MODE12_BIT];
  assign isPm     = hourQ[HOUR_PM_BIT];
  assign atEleven = ({3'b000, hourQ[4:0]} == BCD_11);
  assign monthNum = monthQ & MASK_MONNUM;

  // half of day flips at eleven to twelve
  always_comb
  begin
    if (mode12)
    begin
      hourNext = {1'b0, 1'b1, isPm ^ atEleven, hour12Next[4:0]};
      dayCarry = isPm && atEleven;
    end
    else
    begin
      hourNext = {2'b00, hour24Next[5:0]};
      dayCarry = hour24Wrap;
    end
  end

  // two-digit year divisible by four, no century exception
  // in bcd: even tens with units 0,4,8 or odd tens with units 2,6
  always_comb
  begin
    if (!yearQ[4])
    begin
      leapYear = (yearQ[3:0] == 4'h0) || (yearQ[3:0] == 4'h4) || (yearQ[3:0] == 4'h8);
    end
    else
    begin
      leapYear = (yearQ[3:0] == 4'h2) || (yearQ[3:0] == 4'h6);
    end
  end

  always_comb
  begin
    if (monthNum == BCD_FEB)
    begin
      daysInMonth = leapYear ? BCD_DAYS29 : BCD_DAYS28;
    end
    else if ((monthNum == BCD_APR) || (monthNum == BCD_JUN) || (monthNum == BCD_SEP) || (monthNum == BCD_NOV))
    begin
      daysInMonth = BCD_DAYS30;
    end
    else
    begin
      daysInMonth = BCD_DAYS31;
    end
  end

  // ---------------------------------------------------------------
  // carry chain
  // ---------------------------------------------------------------
  logic minTick;
  logic hourTick;
  logic dayTick;
  logic monthTick;
  logic yearTick;

  assign minTick   = secTick && secWrap;
  assign hourTick  = minTick && minWrap;
  assign dayTick   = hourTick && dayCarry;
  assign monthTick = dayTick && dateWrap;
  assign yearTick  = monthTick && monthWrap;

  // ---------------------------------------------------------------
  // time registers; a host write wins over a tick in the same cycle
  // ---------------------------------------------------------------

  // masked writes keep zero bits zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      secQ <= RST_SEC;
      minQ <= RST_MIN;
    end
    else
    begin
      if (wrSec)
        secQ <= regWrData & MASK_SEC;
      else if (secTick)
        secQ <= secNext;
      if (wrMin)
        minQ <= regWrData & MASK_MIN;
      else if (minTick)
        minQ <= minNext;
    end
  end

  // hours and date
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hourQ <= RST_HOUR;
      dateQ <= RST_DATE;
    end
    else
    begin
      if (wrHour)
        hourQ <= regWrData & MASK_HOUR;
      else if (hourTick)
        hourQ <= hourNext;
      if (wrDate)
        dateQ <= regWrData & MASK_DATE;
      else if (dayTick)
        dateQ <= dateNext;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      monthQ <= RST_MONTH;
      yearQ  <= RST_YEAR;
    end
    else
    begin
      if (wrMonth)
        monthQ <= regWrData & MASK_MONTH;
      else if (monthTick)
        monthQ <= {monthQ[CENTURY_TOGGLE_BIT] ^ (yearTick && yearWrap), monthNext[6:0]};
      if (wrYear)
        yearQ <= regWrData & MASK_YEAR;
      else if (yearTick)
        yearQ <= yearNext;
    end
  end

  // ---------------------------------------------------------------
  // sample interval
  // ---------------------------------------------------------------
  logic [RATE_W-1:0] rateEff;
  logic              unitTick;
  logic              intervalDone;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rateQ <= RST_RATE;
    end
    else if (wrRateLo)
    begin
      rateQ <= {rateQ[RATE_W-1:DATA_W], regWrData};
    end
    else if (wrRateHi)
    begin
      rateQ <= {regWrData[RATE_W-DATA_W-1:0], rateQ[DATA_W-1:0]};
    end
  end

  assign rateEff = (rateQ == '0) ? RATE_W'(1) : rateQ;

  // the host keeps unit and interval consistent
  assign unitTick     = unitSecQ ? secTick : minTick;
  assign intervalDone = (remainQ <= RATE_W'(1));

  // reload after each logging event
  // counter idles loaded so the first event of a mission comes on the rateEff-th unit tick after it starts
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      remainQ <= RST_RATE;
    end
    else if (!missionActive)
    begin
      remainQ <= rateEff;
    end
    else if (unitTick)
    begin
      remainQ <= intervalDone ? rateEff : remainQ - RATE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      logStrobeQ <= 1'b0;
    end
    else
    begin
      logStrobeQ <= missionActive && unitTick && intervalDone;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic rdSec;

  assign rdSec = regRdEn && (regAddr == ADDR_SEC);

  // snapshot at seconds read
  // later bytes come from the snapshot so a rollover mid-read cannot tear them
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      snapMinQ   <= RST_MIN;
      snapHourQ  <= RST_HOUR;
      snapDateQ  <= RST_DATE;
      snapMonthQ <= RST_MONTH;
      snapYearQ  <= RST_YEAR;
    end
    else if (rdSec)
    begin
      snapMinQ   <= minQ;
      snapHourQ  <= hourQ;
      snapDateQ  <= dateQ;
      snapMonthQ <= monthQ;
      snapYearQ  <= yearQ;
    end
  end

  // constant-zero bits read zero
  // unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdDataQ <= '0;
    end
    else if (regRdEn)
    begin
      case (regAddr)
        ADDR_SEC:      rdDataQ <= secQ & MASK_SEC;
        ADDR_MIN:      rdDataQ <= snapMinQ & MASK_MIN;
        ADDR_HOUR:     rdDataQ <= snapHourQ & MASK_HOUR;
        ADDR_DATE:     rdDataQ <= snapDateQ & MASK_DATE;
        ADDR_MONTH:    rdDataQ <= snapMonthQ & MASK_MONTH;
        ADDR_YEAR:     rdDataQ <= snapYearQ & MASK_YEAR;
        ADDR_RATE_LO:  rdDataQ <= rateQ[DATA_W-1:0];
        ADDR_RATE_HI:  rdDataQ <= {2'b00, rateQ[RATE_W-1:DATA_W]};
        ADDR_RTC_CTRL: rdDataQ <= {6'h00, unitSecQ, oscRunQ};
        default:       rdDataQ <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regRdData         = rdDataQ;
  assign oscillatorRun     = oscRunQ;
  assign sampleUnitSeconds = unitSecQ;
  assign secondTick        = secTick;
  assign logStrobe         = logStrobeQ;

endmodule : rtcs_calendar

`default_nettype wire

// ---- logic/rtcs_pkg.sv ----
// constants for the real-time clock, calendar and sample interval block
package rtcs_pkg;

  // ---------------------------------------------------------------
  // register port geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RATE_W = 14;
  localparam int DIV_W  = 32;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SEC      = 16'h0200;
  localparam logic [ADDR_W-1:0] ADDR_MIN      = 16'h0201;
  localparam logic [ADDR_W-1:0] ADDR_HOUR     = 16'h0202;
  localparam logic [ADDR_W-1:0] ADDR_DATE     = 16'h0203;
  localparam logic [ADDR_W-1:0] ADDR_MONTH    = 16'h0204;
  localparam logic [ADDR_W-1:0] ADDR_YEAR     = 16'h0205;
  localparam logic [ADDR_W-1:0] ADDR_RATE_LO  = 16'h0206;
  localparam logic [ADDR_W-1:0] ADDR_RATE_HI  = 16'h0207;
  localparam logic [ADDR_W-1:0] ADDR_RTC_CTRL = 16'h0212;

  // ---------------------------------------------------------------
  // writable bit masks, whose cleared bits are constant zero, and MASK_MONNUM for the month number
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] MASK_SEC     = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_MIN     = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_HOUR    = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_DATE    = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_MONTH   = 8'h9f;
  localparam logic [DATA_W-1:0] MASK_MONNUM  = 8'h1f;
  localparam logic [DATA_W-1:0] MASK_YEAR    = 8'hff;
  localparam logic [DATA_W-1:0] MASK_RATE_HI = 8'h3f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int HOUR_MODE12_BIT = 6;
  localparam int HOUR_PM_BIT     = 5;
  localparam int CENTURY_TOGGLE_BIT        = 7;
  localparam int CTRL_OSC_BIT    = 0;
  localparam int CTRL_UNIT_BIT   = 1;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_SEC   = 8'h00;
  localparam logic [DATA_W-1:0] RST_MIN   = 8'h00;
  localparam logic [DATA_W-1:0] RST_HOUR  = 8'h00;
  localparam logic [DATA_W-1:0] RST_DATE  = 8'h01;
  localparam logic [DATA_W-1:0] RST_MONTH = 8'h01;
  localparam logic [DATA_W-1:0] RST_YEAR  = 8'h00;
  localparam logic [RATE_W-1:0] RST_RATE  = 14'h0001;

  // ---------------------------------------------------------------
  // bcd limits
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] BCD_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0] BCD_ONE    = 8'h01;
  localparam logic [DATA_W-1:0] BCD_59     = 8'h59;
  localparam logic [DATA_W-1:0] BCD_23     = 8'h23;
  localparam logic [DATA_W-1:0] BCD_12     = 8'h12;
  localparam logic [DATA_W-1:0] BCD_11     = 8'h11;
  localparam logic [DATA_W-1:0] BCD_99     = 8'h99;
  localparam logic [DATA_W-1:0] BCD_FEB    = 8'h02;
  localparam logic [DATA_W-1:0] BCD_APR    = 8'h04;
  localparam logic [DATA_W-1:0] BCD_JUN    = 8'h06;
  localparam logic [DATA_W-1:0] BCD_SEP    = 8'h09;
  localparam logic [DATA_W-1:0] BCD_NOV    = 8'h11;
  localparam logic [DATA_W-1:0] BCD_DAYS28 = 8'h28;
  localparam logic [DATA_W-1:0] BCD_DAYS29 = 8'h29;
  localparam logic [DATA_W-1:0] BCD_DAYS30 = 8'h30;
  localparam logic [DATA_W-1:0] BCD_DAYS31 = 8'h31;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SECOND_NS     = 1000000000;
  localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

endpackage : rtcs_pkg
